// file: core/pe_cmd.sv
// Port enable and power-loss recovery command handler for the serial link
`timescale 1ns/100ps
`default_nettype none
`include "pe_defines.svh"
module pe_cmd (
	// Clock and reset
	input  wire logic           clk_sys,
	input  wire logic           arst_n,
	// Mode and factory reset
	input  wire logic           settings_mode,
	input  wire logic           factory_rst,
	// Received bytes
	input  wire logic [7:0]     rx_data,
	input  wire logic           rx_valid,
	// Response bytes
	output logic [7:0]          tx_data,
	output logic                tx_valid,
	input  wire logic           tx_ready,
	// Stored settings
	output var pe_pkg::pe_cfg_s cfg
);
	import pe_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam pe_cfg_s CFG_RST = '{adc_sw: `PE_RST_ADC, adc_ref: `PE_RST_REF,
		in_en: `PE_RST_IN, out_en: `PE_RST_OUT, rec_en: `PE_RST_REC};

	pe_state_e  state_r, state_nxt;
	pe_kind_e   kind_r, kind_nxt;
	logic [5:0] cnt_r, cnt_nxt;
	logic [5:0] pos_r, pos_nxt;
	logic       bad_r, bad_nxt;
	logic       txv_r, txv_nxt;
	logic [7:0] st_r, st_nxt;
	pe_cfg_s    sh_r, sh_nxt;
	pe_cfg_s    cfg_r, cfg_nxt;

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire logic       is_rec   = (kind_r == K_WR_REC);
	wire pe_slot_s   slot     = pe_slot(is_rec, cnt_r);
	wire logic       v_onoff  = (rx_data == `PE_V_ON) || (rx_data == `PE_V_OFF);
	wire logic       v_ref    = (rx_data >= `PE_REF_AVCC) && (rx_data <= `PE_REF_EXT);
	wire logic       v_sep    = (rx_data == `PE_SEP);
	wire logic       byte_ok  = (kind_r == K_RD_EN) ? 1'b1 :
	                            (slot.fld == F_SEP) ? v_sep :
	                            (slot.fld == F_REF) ? v_ref : v_onoff;
	wire logic [5:0] len      = (kind_r == K_RD_EN) ? `PE_LEN_RD :
	                            is_rec ? `PE_LEN_REC : `PE_LEN_EN;
	wire logic [5:0] last_pos = is_rec ? `PE_LAST_REC : `PE_LAST_EN;
	wire logic       is_write = (kind_r != K_RD_EN);
	wire logic       tx_fire  = txv_r && tx_ready;
	wire logic [7:0] verdict  = !is_write ? `PE_ST_OK :
	                            !settings_mode ? `PE_ST_RUN :
	                            bad_r ? `PE_ST_NG : `PE_ST_OK;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		kind_nxt  = kind_r;
		cnt_nxt   = cnt_r;
		pos_nxt   = pos_r;
		bad_nxt   = bad_r;
		txv_nxt   = txv_r;
		st_nxt    = st_r;
		sh_nxt    = sh_r;
		cfg_nxt   = cfg_r;
		case (state_r)
			S_IDLE: begin
				if (rx_valid && rx_data == `PE_LEAD) begin
					state_nxt = S_CODE;
				end
			end
			S_CODE: begin
				if (rx_valid) begin
					cnt_nxt   = 6'd1;
					bad_nxt   = 1'b0;
					sh_nxt    = cfg_r;
					state_nxt = S_DATA;
					case (rx_data)
						`PE_C_WR_EN:  kind_nxt = K_WR_EN;
						`PE_C_RD_EN:  kind_nxt = K_RD_EN;
						`PE_C_WR_REC: kind_nxt = K_WR_REC;
						default:      state_nxt = S_IDLE;
					endcase
				end
			end
			S_DATA: begin
				if (rx_valid) begin
					if (!byte_ok) begin
						bad_nxt = 1'b1;
					end
					if (is_write) begin
						case (slot.fld)
							F_ADC:   sh_nxt.adc_sw[slot.port[1:0]] = (rx_data == `PE_V_SWITCH);
							F_REF:   sh_nxt.adc_ref = rx_data[1:0];
							F_IN:    sh_nxt.in_en[slot.port] = (rx_data == `PE_V_ON);
							F_OUT:   sh_nxt.out_en[slot.port] = (rx_data == `PE_V_ON);
							F_REC:   sh_nxt.rec_en[slot.port] = (rx_data == `PE_V_ON);
							default: sh_nxt = sh_r;
						endcase
					end
					if (cnt_r == len) begin
						state_nxt = S_DONE;
					end else begin
						cnt_nxt = 6'(cnt_r + 6'd1);
					end
				end
			end
			S_DONE: begin
				st_nxt    = verdict;
				if (verdict == `PE_ST_OK && is_write) begin
					cfg_nxt = sh_r;
				end
				pos_nxt   = 6'd0;
				txv_nxt   = 1'b1;
				state_nxt = S_RESP;
			end
			S_RESP: begin
				if (tx_fire) begin
					if (pos_r == last_pos) begin
						txv_nxt   = 1'b0;
						state_nxt = S_IDLE;
					end else begin
						pos_nxt = 6'(pos_r + 6'd1);
					end
				end
			end
			default: state_nxt = S_IDLE;
		endcase
		if (factory_rst) begin
			cfg_nxt = CFG_RST;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= S_IDLE;
			kind_r  <= K_WR_EN;
			cnt_r   <= 6'd0;
			pos_r   <= 6'd0;
			bad_r   <= 1'b0;
			txv_r   <= 1'b0;
			st_r    <= `PE_ST_OK;
			sh_r    <= CFG_RST;
			cfg_r   <= CFG_RST;
		end else begin
			state_r <= state_nxt;
			kind_r  <= kind_nxt;
			cnt_r   <= cnt_nxt;
			pos_r   <= pos_nxt;
			bad_r   <= bad_nxt;
			txv_r   <= txv_nxt;
			st_r    <= st_nxt;
			sh_r    <= sh_nxt;
			cfg_r   <= cfg_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Response byte, built one cycle ahead of its position
	// ----------------------------------------------------------------
	pe_resp_byte u_resp (
		.clk_sys (clk_sys),
		.arst_n  (arst_n),
		.pos     (pos_nxt),
		.kind    (kind_nxt),
		.status  (st_nxt),
		.cfg     (cfg_nxt),
		.byte_r  (tx_data)
	);

	assign tx_valid = txv_r;
	assign cfg      = cfg_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	wire pe_slot_s tx_slot = pe_slot(is_rec, 6'(pos_r - `PE_POS_DATA));

	sequence s_frame_end;
		state_r == S_DONE;
	endsequence

	sequence s_resp_start;
		state_r == S_RESP && pos_r == 6'd0 && txv_r;
	endsequence

	property p_factory;
		@(posedge clk_sys) disable iff (!arst_n)
		factory_rst |=> cfg_r.in_en == `PE_RST_IN && cfg_r.out_en == `PE_RST_OUT;
	endproperty
	a_factory: assert property (p_factory) else $error("factory reset left a port disabled");

	property p_factory_adc;
		@(posedge clk_sys) disable iff (!arst_n)
		factory_rst |=> cfg_r.adc_sw == `PE_RST_ADC;
	endproperty
	a_factory_adc: assert property (p_factory_adc) else $error("factory reset left an adc in switch mode");

	property p_refuse;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_frame_end ##0 (is_write && !settings_mode && !factory_rst)) |=>
			$stable(cfg_r) && st_r == `PE_ST_RUN;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write applied outside settings mode");

	property p_reject;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_frame_end ##0 (is_write && settings_mode && bad_r && !factory_rst)) |=>
			$stable(cfg_r) && st_r == `PE_ST_NG;
	endproperty
	a_reject: assert property (p_reject) else $error("bad write changed stored settings");

	property p_apply;
		@(posedge clk_sys) disable iff (!arst_n)
		(s_frame_end ##0 (is_write && settings_mode && !bad_r && !factory_rst)) |=>
			cfg_r == $past(sh_r) && st_r == `PE_ST_OK;
	endproperty
	a_apply: assert property (p_apply) else $error("accepted write not stored");

	property p_read_ok;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && kind_r == K_RD_EN && pos_r == `PE_POS_DATA && txv_r) |-> tx_data == `PE_ST_OK;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("read answer status not normal");

	property p_code_simple;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && pos_r == 6'd1) |-> tx_data == (is_rec ? `PE_R_REC : `PE_R_EN);
	endproperty
	a_code_simple: assert property (p_code_simple) else $error("wrong response code");

	property p_lead;
		@(posedge clk_sys) disable iff (!arst_n)
		s_resp_start |-> tx_data == `PE_LEAD;
	endproperty
	a_lead: assert property (p_lead) else $error("response does not open with lead char");

	property p_sep;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && pos_r > `PE_POS_DATA && tx_slot.fld == F_SEP) |-> tx_data == `PE_SEP;
	endproperty
	a_sep: assert property (p_sep) else $error("separator missing in response");

	property p_rec_echo;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && is_rec && tx_slot.fld == F_REC) |->
			tx_data == (cfg_r.rec_en[tx_slot.port] ? `PE_V_ON : `PE_V_OFF);
	endproperty
	a_rec_echo: assert property (p_rec_echo) else $error("recovery echo mismatch");

	property p_end;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && tx_fire && pos_r == last_pos) |=> !txv_r && state_r == S_IDLE;
	endproperty
	a_end: assert property (p_end) else $error("response length wrong");

	property p_hold;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && !tx_ready && !factory_rst) |=>
			txv_r && $stable(tx_data) && $stable(pos_r);
	endproperty
	a_hold: assert property (p_hold) else $error("response byte changed while stalled");

	property p_adc_echo;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && !is_rec && tx_slot.fld == F_ADC) |->
			tx_data == (cfg_r.adc_sw[tx_slot.port[1:0]] ? `PE_V_SWITCH : `PE_V_LEVEL);
	endproperty
	a_adc_echo: assert property (p_adc_echo) else $error("adc mode echo mismatch");

	property p_in_echo;
		@(posedge clk_sys) disable iff (!arst_n)
		(state_r == S_RESP && txv_r && !is_rec && tx_slot.fld == F_IN) |->
			tx_data == (cfg_r.in_en[tx_slot.port] ? `PE_V_ON : `PE_V_OFF);
	endproperty
	a_in_echo: assert property (p_in_echo) else $error("input enable echo mismatch");

endmodule : pe_cmd
`default_nettype wire

// file: core/pe_defines.svh
// Byte codes, frame lengths and reset values for the port enable and recovery command handler
`ifndef PE_DEFINES_SVH
`define PE_DEFINES_SVH

// ----------------------------------------------------------------
// Command and response codes (second character follows the lead)
// ----------------------------------------------------------------
`define PE_LEAD       8'h31
`define PE_C_WR_EN    8'h31
`define PE_C_RD_EN    8'h33
`define PE_C_WR_REC   8'h34
`define PE_R_EN       8'h32
`define PE_R_REC      8'h35

// ----------------------------------------------------------------
// Data byte values
// ----------------------------------------------------------------
`define PE_SEP        8'h2c
`define PE_V_ON       8'h31
`define PE_V_OFF      8'h32
`define PE_V_LEVEL    8'h31
`define PE_V_SWITCH   8'h32
`define PE_REF_AVCC   8'h30
`define PE_REF_EXT    8'h32
`define PE_REF_BASE   6'h0c
`define PE_ST_OK      8'h30
`define PE_ST_RUN     8'h31
`define PE_ST_NG      8'h39

// ----------------------------------------------------------------
// Frame lengths in data bytes and last response position
// ----------------------------------------------------------------
`define PE_LEN_EN     6'h22
`define PE_LEN_REC    6'h0c
`define PE_LEN_RD     6'h01
`define PE_LAST_EN    6'h24
`define PE_LAST_REC   6'h0e
`define PE_POS_DATA   6'h02

// ----------------------------------------------------------------
// Settings after reset or factory reset
// ----------------------------------------------------------------
`define PE_RST_ADC    4'h0
`define PE_RST_REF    2'h0
`define PE_RST_IN     12'hfff
`define PE_RST_OUT    10'h3ff
`define PE_RST_REC    10'h3ff

`endif

// file: core/pe_pkg.sv
// Types and the shared frame layout decoder of the port enable and recovery command handler
`default_nettype none
package pe_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {K_WR_EN, K_RD_EN, K_WR_REC} pe_kind_e;
	typedef enum logic [2:0] {F_SEP, F_ADC, F_REF, F_IN, F_OUT, F_REC} pe_fld_e;
	typedef enum logic [2:0] {S_IDLE, S_CODE, S_DATA, S_DONE, S_RESP} pe_state_e;

	typedef struct packed {
		logic [3:0]  adc_sw;
		logic [1:0]  adc_ref;
		logic [11:0] in_en;
		logic [9:0]  out_en;
		logic [9:0]  rec_en;
	} pe_cfg_s;

	typedef struct packed {
		pe_fld_e     fld;
		logic [3:0]  port;
	} pe_slot_s;

	// ----------------------------------------------------------------
	// Field and port carried by data byte idx (1-based)
	// ----------------------------------------------------------------
	function automatic pe_slot_s pe_slot(input logic rec, input logic [5:0] idx);
		pe_slot_s s;
		s.fld  = F_SEP;
		s.port = 4'h0;
		if (rec) begin
			if (idx >= 6'd1 && idx <= 6'd4) begin
				s.fld  = F_REC;
				s.port = 4'(idx - 6'd1);
			end else if (idx >= 6'd6 && idx <= 6'd9) begin
				s.fld  = F_REC;
				s.port = 4'(idx - 6'd2);
			end else if (idx >= 6'd11 && idx <= 6'd12) begin
				s.fld  = F_REC;
				s.port = 4'(idx - 6'd3);
			end
		end else begin
			if (idx >= 6'd1 && idx <= 6'd4) begin
				s.fld  = F_ADC;
				s.port = 4'(idx - 6'd1);
			end else if (idx == 6'd6) begin
				s.fld  = F_REF;
			end else if (idx >= 6'd8 && idx <= 6'd11) begin
				s.fld  = F_IN;
				s.port = 4'(idx - 6'd8);
			end else if (idx >= 6'd13 && idx <= 6'd16) begin
				s.fld  = F_IN;
				s.port = 4'(idx - 6'd9);
			end else if (idx >= 6'd18 && idx <= 6'd21) begin
				s.fld  = F_IN;
				s.port = 4'(idx - 6'd10);
			end else if (idx >= 6'd23 && idx <= 6'd26) begin
				s.fld  = F_OUT;
				s.port = 4'(idx - 6'd23);
			end else if (idx >= 6'd28 && idx <= 6'd31) begin
				s.fld  = F_OUT;
				s.port = 4'(idx - 6'd24);
			end else if (idx >= 6'd33 && idx <= 6'd34) begin
				s.fld  = F_OUT;
				s.port = 4'(idx - 6'd25);
			end
		end
		return s;
	endfunction : pe_slot

endpackage : pe_pkg
`default_nettype wire

// file: core/pe_resp_byte.sv
// Registered response byte generator: code characters, status and stored settings
`timescale 1ns/100ps
`default_nettype none
`include "pe_defines.svh"
module pe_resp_byte (
	// Clock and reset
	input  wire logic           clk_sys,
	input  wire logic           arst_n,
	// Position and content
	input  wire logic [5:0]     pos,
	input  wire pe_pkg::pe_kind_e kind,
	input  wire logic [7:0]     status,
	input  wire pe_pkg::pe_cfg_s cfg,
	// Byte out
	output logic [7:0]          byte_r
);
	import pe_pkg::*;

	// ----------------------------------------------------------------
	// Byte selection
	// ----------------------------------------------------------------
	wire logic       is_rec   = (kind == K_WR_REC);
	wire pe_slot_s   slot     = pe_slot(is_rec, 6'(pos - `PE_POS_DATA));
	wire logic [7:0] code_b   = is_rec ? `PE_R_REC : `PE_R_EN;
	wire logic [7:0] adc_b    = cfg.adc_sw[slot.port[1:0]] ? `PE_V_SWITCH : `PE_V_LEVEL;
	wire logic [7:0] ref_b    = {`PE_REF_BASE, cfg.adc_ref};
	wire logic [7:0] in_b     = cfg.in_en[slot.port] ? `PE_V_ON : `PE_V_OFF;
	wire logic [7:0] out_b    = cfg.out_en[slot.port] ? `PE_V_ON : `PE_V_OFF;
	wire logic [7:0] rec_b    = cfg.rec_en[slot.port] ? `PE_V_ON : `PE_V_OFF;
	logic      [7:0] byte_nxt;

	always_comb begin
		byte_nxt = `PE_SEP;
		if (pos == 6'd0) begin
			byte_nxt = `PE_LEAD;
		end else if (pos == 6'd1) begin
			byte_nxt = code_b;
		end else if (pos == `PE_POS_DATA) begin
			byte_nxt = status;
		end else begin
			case (slot.fld)
				F_ADC:   byte_nxt = adc_b;
				F_REF:   byte_nxt = ref_b;
				F_IN:    byte_nxt = in_b;
				F_OUT:   byte_nxt = out_b;
				F_REC:   byte_nxt = rec_b;
				default: byte_nxt = `PE_SEP;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			byte_r <= 8'h00;
		end else begin
			byte_r <= byte_nxt;
		end
	end

endmodule : pe_resp_byte
`default_nettype wire

// file: test/pe_host.sv
// Host model that sends command frames and collects the response bytes
`timescale 1ns/100ps
`default_nettype none
module pe_host (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       arst_n,
	// Command bytes to the handler
	output logic [7:0]      rx_data,
	output logic            rx_valid,
	// Response bytes from the handler
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// Pacing: stall every other cycle and space the command bytes
	input  wire logic       slow
);
	logic [7:0] resp[$];
	logic [3:0] tick;

	initial begin
		rx_data  = 8'h5a;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		tick     = 4'h0;
	end

	// ----------------------------------------------------------------
	// Response sink
	// ----------------------------------------------------------------
	always @(posedge clk_sys) begin
		tick     <= tick + 4'h1;
		tx_ready <= arst_n && (!slow || tick[0]);
		if (tx_valid && tx_ready)
			resp.push_back(tx_data);
	end

	// ----------------------------------------------------------------
	// Frame sender, entered just after a clock edge
	// ----------------------------------------------------------------
	task automatic send(input logic [7:0] b[$], input logic gap);
		foreach (b[i]) begin
			rx_data  <= b[i];
			rx_valid <= 1'b1;
			@(posedge clk_sys);
			if (gap) begin
				rx_valid <= 1'b0;
				rx_data  <= ~b[i];
				@(posedge clk_sys);
			end
		end
		rx_valid <= 1'b0;
		rx_data  <= ~rx_data;
	endtask : send
endmodule : pe_host
`default_nettype wire

// file: test/port_enable_recovery_cmds_tb_top.sv
// Testbench for the port enable and power-loss recovery command handler
`timescale 1ns/100ps
`default_nettype none
module port_enable_recovery_cmds_tb_top;
	import pe_pkg::*;
	typedef logic [7:0] pe_q_t[$];
	localparam pe_cfg_s DFLT = '{4'h0, 2'h0, 12'hfff, 10'h3ff, 10'h3ff};
	logic       clk_sys, arst_n, settings_mode, factory_rst, slow;
	logic [7:0] rx_data, tx_data;
	logic       rx_valid, tx_valid, tx_ready;
	pe_cfg_s    cfg, ec;
	int         fail_count, n_tests;
	int         bad_at[4]  = '{1, 6, 12, 34};
	logic [7:0] bad_val[4] = '{8'h30, 8'h33, 8'h2d, 8'h30};
	pe_q_t      f;

	pe_cmd dut (.clk_sys(clk_sys), .arst_n(arst_n), .settings_mode(settings_mode), .factory_rst(factory_rst),
		.rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.cfg(cfg));
	pe_host host (.clk_sys(clk_sys), .arst_n(arst_n), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ----------------------------------------------------------------
	// Frame encoders and checking tasks
	// ----------------------------------------------------------------
	function automatic pe_q_t out_bytes(logic [9:0] v, logic lead);
		pe_q_t q;
		for (int i = 0; i < 10; i++) begin
			if (i % 4 == 0 && (lead || i > 0))
				q.push_back(8'h2c);
			q.push_back(v[i] ? 8'h31 : 8'h32);
		end
		return q;
	endfunction : out_bytes

	function automatic pe_q_t en_data(pe_cfg_s c);
		pe_q_t q;
		for (int i = 0; i < 4; i++)
			q.push_back(c.adc_sw[i] ? 8'h32 : 8'h31);
		q.push_back(8'h2c);
		q.push_back(8'h30 + 8'(c.adc_ref));
		for (int i = 0; i < 12; i++) begin
			if (i % 4 == 0)
				q.push_back(8'h2c);
			q.push_back(c.in_en[i] ? 8'h31 : 8'h32);
		end
		q = {q, out_bytes(c.out_en, 1'b1)};
		return q;
	endfunction : en_data

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic xfer(input pe_q_t fr, input logic [7:0] rc, input logic [7:0] st, input pe_q_t d);
		int    k;
		pe_q_t e;
		e = {8'h31, rc, st};
		e = {e, d};
		host.resp.delete();
		host.send(fr, slow);
		k = 0;
		while (host.resp.size() < e.size() && k < 500) begin
			@(posedge clk_sys);
			k++;
		end
		repeat (4) @(posedge clk_sys);
		check(64'(host.resp.size()), 64'(e.size()));
		foreach (e[i])
			check(host.resp[i], e[i]);
		check(cfg, ec);
	endtask : xfer

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		settings_mode = 1'b1;
		factory_rst   = 1'b0;
		slow          = 1'b0;
		arst_n        = 1'b0;
		fail_count    = 0;
		n_tests       = 0;
		ec            = DFLT;
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		check(cfg, ec);
		xfer('{8'h31, 8'h33, 8'h30}, 8'h32, 8'h30, en_data(ec));
		$display("test defaults done");
		for (int r = 0; r < 3; r++) begin
			ec.adc_sw  = {r[1:0], ~r[1:0]};
			ec.adc_ref = r[1:0];
			ec.in_en   = 12'ha5c ^ {12{r[0]}};
			ec.out_en  = 10'h2b3 ^ {10{r[1]}};
			f = {8'h31, 8'h31, en_data(ec)};
			xfer(f, 8'h32, 8'h30, en_data(ec));
		end
		$display("test enable writes done");
		settings_mode <= 1'b0;
		f = {8'h31, 8'h31, en_data(DFLT)};
		xfer(f, 8'h32, 8'h31, en_data(ec));
		settings_mode <= 1'b1;
		foreach (bad_at[i]) begin
			f = {8'h31, 8'h31, en_data(DFLT)};
			f[bad_at[i] + 1] = bad_val[i];
			xfer(f, 8'h32, 8'h39, en_data(ec));
		end
		$display("test refused writes done");
		slow <= 1'b1;
		ec.rec_en = 10'h15a;
		f = {8'h31, 8'h34, out_bytes(ec.rec_en, 1'b0)};
		xfer(f, 8'h35, 8'h30, out_bytes(ec.rec_en, 1'b0));
		settings_mode <= 1'b0;
		f = {8'h31, 8'h34, out_bytes(10'h0f0, 1'b0)};
		xfer(f, 8'h35, 8'h31, out_bytes(ec.rec_en, 1'b0));
		settings_mode <= 1'b1;
		f[6] = 8'h31;
		xfer(f, 8'h35, 8'h39, out_bytes(ec.rec_en, 1'b0));
		slow <= 1'b0;
		$display("test recovery done");
		factory_rst <= 1'b1;
		@(posedge clk_sys);
		factory_rst <= 1'b0;
		@(posedge clk_sys);
		ec = DFLT;
		host.send('{8'h31, 8'h37, 8'h30}, 1'b0);
		@(posedge clk_sys);
		xfer('{8'h31, 8'h33, 8'h30}, 8'h32, 8'h30, en_data(ec));
		$display("test factory reset done");
		wrap_up();
	end

	initial begin
		repeat (10000) @(posedge clk_sys);
		fail_count++;
		wrap_up();
	end
endmodule : port_enable_recovery_cmds_tb_top
`default_nettype wire
